/* File: aom_defines.vh */
// aom_defines.vh: constants for the adc output sync and mode block
// assumes inclusion by bare name from the design file
`ifndef AOM_DEFINES_VH
`define AOM_DEFINES_VH
// register indices (word index on the bus)
`define AOM_IDX_MODE 7'h31
`define AOM_IDX_STATUS 7'h32
// mode control register layout and default
`define AOM_MODE_DEFAULT 8'hc0
`define AOM_B_REGDEF 7
`define AOM_B_SYSRST 6
`define AOM_B_MDHI 5
`define AOM_B_MDLO 4
`define AOM_B_FMT 3
`define AOM_B_PDN 2
`define AOM_B_POL 1
`define AOM_B_MUTE 0
// timing counts
`define AOM_RST_CYCLES 11'h400
`define AOM_SETTLE_SMP 14'h0020
`define AOM_FADE_STEPS 6'h30
// lock window in bit clocks per frame format
`define AOM_BPF64 8'h40
`define AOM_BPF48 8'h30
`define AOM_HI64 8'h06
`define AOM_LO64 8'h05
`define AOM_HI48 8'h05
`define AOM_LO48 8'h04
// s-curve gain scaling
`define AOM_CURVE_K 18'h00090
`define AOM_CURVE_MUL 22'h000013
`endif

/* File: aom_dsp_model.sv */
// aom_dsp_model.sv: audio processor on the serial link
// assumes slave link, 160 ns bit clock, left-justified, 48 bit clocks
`timescale 1ns/1ps
`default_nettype none
module aom_dsp_model (
  // link clocks out
  output logic frameClock,
  output logic bitClock,
  // serial data in, slip control
  input wire logic serialIn,
  input wire logic [3:0] slipBits,
  // captured words
  output logic [23:0] leftWord,
  output logic [23:0] rightWord,
  output logic [31:0] frameCount
);
  integer h, i, s;
  logic [23:0] sh;
  // free-running frames, phase unrelated to clk_sys
  initial
  begin
    {frameClock, bitClock, leftWord, rightWord, frameCount, sh} = '0;
    forever
    begin
      s = slipBits; // a slip stretches one frame
      for (h = 0; h < 2; h = h + 1)
      begin
        for (i = 0; i < 24 + h * s; i = i + 1)
        begin
          #80 bitClock = 1'h0;
          if (i == 0) frameClock = !h; // frame edge on falling bit clock
          #80 bitClock = 1'h1;
          if (i < 24) sh = {sh[22:0], serialIn}; // msb first
        end
        if (h == 0) leftWord = sh;
        else rightWord = sh;
      end
      frameCount = frameCount + 1;
    end
  end
endmodule
`default_nettype wire

/* File: aom_top.v */
// aom_top.v: output sync monitor, fades, mute, polarity, power modes
// assumes frame and bit clock arrive asynchronously as slave inputs,
// samples come from the decimator on clk_sys, registers over avalon-mm
//
// Summary of operation
// [R1] slave mode follows frame clock, any phase
// [R2] drift over six/five bit clocks forces zero
// [R3] drift under five/four bit clocks ignored
// [R4] relock: 32 samples invalid, then fade in
// [R5] lock loss aborts fade, restart after 32
// [R6] mute bit fades out, clearing fades in
// [R7] polarity bit inverts samples immediately, default normal
// [R8] host mutes before toggling polarity bit
// [R9] register default bit low restores mode register
// [R10] power down zeroes output, gates clock
// [R11] power down fades out, release fades in
// [R12] release: 1024 cycles, 8960 samples, fade
// [R13] system reset zeroes at once, powers down
// [R14] host resets when changing rate or mode
// [R15] s-curve fades, zero-cross, timeout forces 48
// [R16] mode register at index 31h, bit order
// [R17] forced zero keeps normal serial framing
`include "aom_defines.vh"
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
// small sample fifo, flop storage
module aom_fifo #(
  parameter WIDTH = 48,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  input wire flush,
  // fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0] wrPtr_q;
  reg [AW:0] rdPtr_q;
  localparam [AW:0] FULL = DEPTH; // fill level that blocks the input
  wire [AW:0] used;
  assign used = wrPtr_q - rdPtr_q;
  assign inReady = (used != FULL);
  assign outValid = (used != {(AW+1){1'b0}});
  assign outData = mem_q[rdPtr_q[AW-1:0]];
  // pointer update
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPtr_q <= {(AW+1){1'b0}};
      rdPtr_q <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      wrPtr_q <= {(AW+1){1'b0}};
      rdPtr_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (inValid && inReady)
        wrPtr_q <= wrPtr_q + 1'b1;
      if (outValid && outReady)
        rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
  // storage write
  always @(posedge clk_sys)
  begin
    if (inValid && inReady && !flush)
      mem_q[wrPtr_q[AW-1:0]] <= inData;
  end
endmodule

////////////////////////////////////////////////////////////////////////
module aom_top #(
  parameter WARM_SAMPLES = 14'd8960,
  parameter ZC_TIMEOUT = 14'd8192,
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2
) (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // avalon-mm slave
  input wire [6:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // decimated samples in
  input wire smpValid,
  output wire smpReady,
  input wire [23:0] smpLeft,
  input wire [23:0] smpRight,
  // serial link
  input wire frameClock,
  input wire bitClock,
  output reg serialOut_q,
  // power and mode
  output reg analogPowerDown_q,
  output reg digitalClockGate_q,
  output wire [1:0] interfaceModeSel,
  output wire formatSel
);
  localparam ST_RSTW = 4'h0;
  localparam ST_WARM = 4'h1;
  localparam ST_SETTLE = 4'h2;
  localparam ST_FADEIN = 4'h3;
  localparam ST_RUN = 4'h4;
  localparam ST_FADEOUT = 4'h5;
  localparam ST_MUTED = 4'h6;
  localparam ST_PDN = 4'h7;
  localparam ST_UNLK = 4'h8;

  reg [7:0] modeReg_q;
  reg ack_q;
  reg [3:0] state_q;
  reg [5:0] step_q;
  reg [10:0] rstCnt_q;
  reg [13:0] smpCnt_q;
  reg [13:0] zcTimer_q;
  reg forced_q;
  reg prevSign_q;
  reg locked_q;
  reg haveRef_q;
  reg [15:0] frameLen_q;
  reg [15:0] lastLen_q;
  reg [7:0] bckCnt_q;
  reg bpf48_q;
  reg frm1_q, frm2_q, frm3_q;
  reg bck1_q, bck2_q, bck3_q;
  reg [47:0] chanOut_q;
  reg [23:0] word_q;
  reg [5:0] bitPos_q;

  wire pdn = modeReg_q[`AOM_B_PDN];
  wire mute = modeReg_q[`AOM_B_MUTE];
  wire fmtLj = modeReg_q[`AOM_B_FMT];
  wire slave = (modeReg_q[`AOM_B_MDHI:`AOM_B_MDLO] == 2'b00);
  assign interfaceModeSel = modeReg_q[`AOM_B_MDHI:`AOM_B_MDLO];
  assign formatSel = fmtLj;

  ////////////////////////////////////////////////////////////////////
  // register bus: one wait cycle, then answer
  wire busReq = avs_read | avs_write;
  assign avs_waitrequest = busReq & ~ack_q;
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h00000000;
      modeReg_q <= `AOM_MODE_DEFAULT;
    end
    else
    begin
      ack_q <= busReq & ~ack_q;
      if (avs_read && !ack_q)
      begin
        if (avs_address == `AOM_IDX_MODE)
          avs_readdata <= {24'h000000, modeReg_q}; // see [R16]
        else if (avs_address == `AOM_IDX_STATUS)
          avs_readdata <= {20'h00000, bpf48_q, locked_q, step_q, state_q};
        else
          avs_readdata <= 32'h00000000;
      end
      if (avs_write && ack_q && avs_address == `AOM_IDX_MODE)
      begin
        if (!avs_writedata[`AOM_B_REGDEF])
          modeReg_q <= `AOM_MODE_DEFAULT; // see [R9]
        else
          modeReg_q <= avs_writedata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // link clock synchronisers and edge detect
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      {frm1_q, frm2_q, frm3_q} <= 3'h0;
      {bck1_q, bck2_q, bck3_q} <= 3'h0;
    end
    else
    begin
      frm1_q <= frameClock;
      frm2_q <= frm1_q;
      frm3_q <= frm2_q;
      bck1_q <= bitClock;
      bck2_q <= bck1_q;
      bck3_q <= bck2_q;
    end
  end
  wire frmEdge = frm2_q ^ frm3_q;
  wire leftStart = frmEdge & (frm2_q == fmtLj);
  wire bckRise = bck2_q & ~bck3_q;
  wire bckFall = ~bck2_q & bck3_q;
  wire tick = leftStart; // one per sample period, see [R1]

  ////////////////////////////////////////////////////////////////////
  // lock monitor: frame length in clk_sys against previous frame
  wire [15:0] lenDiff = (frameLen_q > lastLen_q) ?
    frameLen_q - lastLen_q : lastLen_q - frameLen_q;
  wire [7:0] bpf = bpf48_q ? `AOM_BPF48 : `AOM_BPF64;
  wire [7:0] thrHi = bpf48_q ? `AOM_HI48 : `AOM_HI64;
  wire [7:0] thrLo = bpf48_q ? `AOM_LO48 : `AOM_LO64;
  wire [23:0] driftScaled = lenDiff * bpf;
  wire [23:0] limHi = lastLen_q * thrHi;
  wire [23:0] limLo = lastLen_q * thrLo;
  wire lenSat = (frameLen_q == 16'hffff);
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      frameLen_q <= 16'h0000;
      lastLen_q <= 16'h0000;
      bckCnt_q <= 8'h00;
      bpf48_q <= 1'b0;
      haveRef_q <= 1'b0;
      locked_q <= 1'b0;
    end
    else if (state_q == ST_PDN)
    begin
      frameLen_q <= 16'h0000;
      haveRef_q <= 1'b0;
      locked_q <= 1'b0;
    end
    else if (!slave)
      locked_q <= 1'b1;
    else if (tick)
    begin
      frameLen_q <= 16'h0001;
      lastLen_q <= frameLen_q;
      haveRef_q <= 1'b1;
      bckCnt_q <= 8'h00;
      bpf48_q <= (bckCnt_q == `AOM_BPF48);
      if (haveRef_q && driftScaled > limHi)
        locked_q <= 1'b0; // see [R2]
      else if (haveRef_q && driftScaled < limLo)
        locked_q <= 1'b1; // see [R3]
    end
    else
    begin
      if (!lenSat)
        frameLen_q <= frameLen_q + 16'h0001;
      else
        locked_q <= 1'b0; // frame clock stopped
      if (bckRise && bckCnt_q != 8'hff)
        bckCnt_q <= bckCnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sample fifo, drained once per frame while converting
  wire halted = (state_q == ST_PDN) | (state_q == ST_RSTW) | (state_q == ST_UNLK);
  wire fifoValid;
  wire [47:0] fifoData;
  wire pop = tick & ~halted;
  aom_fifo #(.WIDTH(48), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) uFifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .flush(state_q == ST_PDN),
    .inValid(smpValid),
    .inReady(smpReady),
    .inData({smpRight, smpLeft}),
    .outValid(fifoValid),
    .outReady(pop),
    .outData(fifoData)
  );
  wire [47:0] rawPair = fifoValid ? fifoData : 48'h000000000000;
  wire zeroCross = prevSign_q & ~rawPair[23];
  wire stepEv = tick & (zeroCross | forced_q); // see [R15]
  wire fading = (state_q == ST_FADEIN) | (state_q == ST_FADEOUT);
  wire audible = fading | (state_q == ST_RUN);

  // s-curve gain 3t^2-2t^3 over 48 steps, scaled to 2^17
  function [23:0] applyGain;
    input [23:0] s;
    input [5:0] st;
    reg [17:0] stW;
    reg [17:0] g;
    reg [21:0] gs;
    reg signed [42:0] p;
    begin
      stW = {12'h000, st};
      g = stW * stW * (`AOM_CURVE_K - {stW[16:0], 1'b0});
      gs = {4'h0, g} * `AOM_CURVE_MUL;
      p = $signed(s) * $signed({1'b0, gs[21:4]});
      applyGain = p[40:17];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // per channel gain, zero force and polarity
  wire [47:0] procPair;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : gChan
      wire [23:0] raw = rawPair[ch*24 +: 24];
      wire [23:0] gained = (step_q == `AOM_FADE_STEPS) ? raw : applyGain(raw, step_q);
      wire [23:0] shaped = audible ? gained : 24'h000000; // see [R17]
      wire [23:0] negated = (shaped == 24'h800000) ? 24'h7fffff : (24'h000000 - shaped);
      assign procPair[ch*24 +: 24] = modeReg_q[`AOM_B_POL] ? negated : shaped; // see [R7]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // zero-cross timeout and sign history
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      zcTimer_q <= 14'h0000;
      forced_q <= 1'b0;
      prevSign_q <= 1'b0;
    end
    else
    begin
      if (tick)
        prevSign_q <= rawPair[23];
      if (!fading)
      begin
        zcTimer_q <= 14'h0000;
        forced_q <= 1'b0;
      end
      else if (tick && zcTimer_q == ZC_TIMEOUT - 14'h0001)
        forced_q <= 1'b1; // see [R15]
      else if (tick)
        zcTimer_q <= zcTimer_q + 14'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // output sequencing state machine
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_RSTW;
      step_q <= 6'h00;
      rstCnt_q <= 11'h000;
      smpCnt_q <= 14'h0000;
    end
    else if (!modeReg_q[`AOM_B_SYSRST])
    begin
      state_q <= ST_PDN; // see [R13]
      step_q <= 6'h00;
    end
    else
    begin
      case (state_q)
        ST_PDN:
          if (!pdn)
          begin
            state_q <= ST_RSTW;
            rstCnt_q <= 11'h000;
          end
        ST_RSTW:
          if (pdn)
            state_q <= ST_PDN;
          else if (rstCnt_q == `AOM_RST_CYCLES - 11'h001)
          begin
            state_q <= ST_WARM; // see [R12]
            smpCnt_q <= 14'h0000;
          end
          else
            rstCnt_q <= rstCnt_q + 11'h001;
        ST_WARM:
          if (pdn)
            state_q <= ST_PDN;
          else if (tick && smpCnt_q == WARM_SAMPLES - 14'h0001)
            state_q <= !locked_q ? ST_UNLK : (mute ? ST_MUTED : ST_FADEIN); // see [R12]
          else if (tick)
            smpCnt_q <= smpCnt_q + 14'h0001;
        ST_UNLK:
          if (pdn)
            state_q <= ST_PDN;
          else if (locked_q)
          begin
            state_q <= ST_SETTLE;
            smpCnt_q <= 14'h0000;
          end
        ST_SETTLE:
          if (pdn)
            state_q <= ST_PDN;
          else if (!locked_q)
            state_q <= ST_UNLK;
          else if (tick && smpCnt_q == `AOM_SETTLE_SMP - 14'h0001)
          begin
            state_q <= mute ? ST_MUTED : ST_FADEIN; // see [R4]
            step_q <= 6'h00; // see [R5]
          end
          else if (tick)
            smpCnt_q <= smpCnt_q + 14'h0001;
        ST_FADEIN:
          if (!locked_q)
          begin
            state_q <= ST_UNLK; // see [R5]
            step_q <= 6'h00;
          end
          else if (pdn || mute)
            state_q <= ST_FADEOUT; // see [R6]
          else if (stepEv)
          begin
            step_q <= step_q + 6'h01;
            if (step_q == `AOM_FADE_STEPS - 6'h01)
              state_q <= ST_RUN; // see [R4]
          end
        ST_RUN:
          if (!locked_q)
          begin
            state_q <= ST_UNLK; // see [R2]
            step_q <= 6'h00;
          end
          else if (pdn || mute)
            state_q <= ST_FADEOUT; // see [R11]
        ST_FADEOUT:
          if (!locked_q)
          begin
            state_q <= ST_UNLK;
            step_q <= 6'h00;
          end
          else if (!pdn && !mute)
            state_q <= ST_FADEIN; // see [R6]
          else if (step_q == 6'h00)
            state_q <= pdn ? ST_PDN : ST_MUTED; // already silent, no wrap below zero
          else if (stepEv)
          begin
            step_q <= step_q - 6'h01;
            if (step_q == 6'h01)
              state_q <= pdn ? ST_PDN : ST_MUTED; // see [R11]
          end
        ST_MUTED:
          if (pdn)
            state_q <= ST_PDN; // see [R10]
          else if (!locked_q)
            state_q <= ST_UNLK;
          else if (!mute)
          begin
            state_q <= ST_FADEIN; // see [R6]
            step_q <= 6'h00;
          end
        default:
          state_q <= ST_PDN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // power outputs follow the power-down state
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      analogPowerDown_q <= 1'b0;
      digitalClockGate_q <= 1'b0;
    end
    else
    begin
      analogPowerDown_q <= (state_q == ST_PDN); // see [R10]
      digitalClockGate_q <= (state_q == ST_PDN);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // serialiser: msb first, i2s one bit late, left-justified on the edge
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      chanOut_q <= 48'h000000000000;
      word_q <= 24'h000000;
      bitPos_q <= 6'h00;
      serialOut_q <= 1'b0;
    end
    else if (state_q == ST_PDN || !modeReg_q[`AOM_B_SYSRST])
    begin
      // drop the word in flight so zero shows at once, see [R13]
      chanOut_q <= 48'h000000000000;
      word_q <= 24'h000000;
      serialOut_q <= 1'b0;
    end
    else if (frmEdge)
    begin
      bitPos_q <= 6'h00;
      if (leftStart)
      begin
        chanOut_q <= procPair;
        word_q <= procPair[23:0];
        serialOut_q <= fmtLj ? procPair[23] : 1'b0;
      end
      else
      begin
        word_q <= chanOut_q[47:24];
        serialOut_q <= fmtLj ? chanOut_q[47] : 1'b0;
      end
    end
    else if (bckFall)
    begin
      if (bitPos_q != 6'h3f)
        bitPos_q <= bitPos_q + 6'h01;
      if (fmtLj)
        serialOut_q <= (bitPos_q < 6'h17) ? word_q[5'h16 - bitPos_q[4:0]] : 1'b0;
      else
        serialOut_q <= (bitPos_q < 6'h18) ? word_q[5'h17 - bitPos_q[4:0]] : 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: aom_top_chk.sv */
// aom_top_chk.sv: port checker for aom_top
// assumes bind onto aom_top, single clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module aom_top_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register bus
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // link and power
  input wire logic serialOut_q,
  input wire logic analogPowerDown_q,
  input wire logic digitalClockGate_q,
  input wire logic [1:0] interfaceModeSel,
  input wire logic formatSel
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire logic modeWr;
  // accepted write to the mode register
  assign modeWr = avs_write && !avs_waitrequest && avs_address == 7'h31;
  wait_one_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait state");
  idle_ready_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  mode_hold_a: assert property (!modeWr |=> $stable({interfaceModeSel, formatSel}))
    else $error("mode bits moved without write");
  mode_write_a: assert property (modeWr && avs_writedata[7] |=> {interfaceModeSel, formatSel} == $past(avs_writedata[5:3]))
    else $error("mode bits not taken from write");
  reg_default_a: assert property (modeWr && !avs_writedata[7] |=> interfaceModeSel == 2'h0 && !formatSel)
    else $error("mode register not defaulted");
  unmapped_read_a: assert property (avs_read && !avs_waitrequest && avs_address != 7'h31 && avs_address != 7'h32
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  clock_gate_a: assert property (analogPowerDown_q == digitalClockGate_q)
    else $error("clock gate differs from power down");
  pdn_zero_a: assert property (analogPowerDown_q [*2] |-> !serialOut_q)
    else $error("serial data while powered down");
  sys_reset_a: assert property (modeWr && avs_writedata[7] && !avs_writedata[6]
    |-> ##[1:3] analogPowerDown_q && !serialOut_q)
    else $error("system reset not immediate");
endmodule
bind aom_top aom_top_chk aom_top_chk_inst (.clk_sys, .resetn, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .serialOut_q, .analogPowerDown_q,
  .digitalClockGate_q, .interfaceModeSel, .formatSel);
`default_nettype wire

/* File: aom_top_test.sv */
// aom_top_test.sv: self-checking bench for aom_top
// assumes aom_dsp_model drives the link, checker bound separately
`timescale 1ns/1ps
`default_nettype none
module aom_top_test;
  logic clk_sys = 1'h0;
  logic resetn = 1'h0;
  logic [6:0] avs_address = 7'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, smpReady, frameClock, bitClock, serialOut_q;
  logic smpValid = 1'h0;
  logic [23:0] smpLeft = 24'h0;
  logic [23:0] smpRight = 24'h0;
  logic analogPowerDown_q, digitalClockGate_q, formatSel;
  logic [1:0] interfaceModeSel;
  logic [3:0] slipBits = 4'h0;
  logic [23:0] leftWord, rightWord;
  logic [31:0] frameCount, rd, r;
  integer bad_count = 0;
  integer tests_run = 0;
  integer seed = 8180;
  integer cyc = 0;
  integer t0;
  ////////////////////////////////////////
  aom_top #(.WARM_SAMPLES(14'd16), .ZC_TIMEOUT(14'd8)) aom_top_inst (.clk_sys, .resetn, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .smpValid, .smpReady,
    .smpLeft, .smpRight, .frameClock, .bitClock, .serialOut_q, .analogPowerDown_q,
    .digitalClockGate_q, .interfaceModeSel, .formatSel);
  aom_dsp_model aom_dsp_model_inst (.frameClock, .bitClock, .serialIn(serialOut_q), .slipBits,
    .leftWord, .rightWord, .frameCount);
  // clock and cycle count, clock never halts
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  ////////////////////////////////////////
  // negated sample, expected with inverted polarity
  function [23:0] neg24(input logic [23:0] v);
    neg24 = 24'h0 - v;
  endfunction
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one avalon transfer, held until waitrequest low
  task bus(input logic w, input logic [6:0] a, input logic [7:0] d);
    integer n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'h0 && n < 50)
    begin
      @(posedge clk_sys);
      n = n + 1;
    end
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (n == 50) chk(32'h0, 32'h1);
  endtask
  // poll status until the state field matches
  task waitSt(input logic [3:0] s, input integer lim);
    integer k;
    k = 0;
    rd = 32'hf;
    while (rd[3:0] !== s && k < lim)
    begin
      bus(1'h0, 7'h32, 8'h0);
      k = k + 1;
    end
    chk(rd[3:0], s);
  endtask
  // wait whole frames
  task waitF(input integer n);
    repeat (n) @(frameCount);
  endtask
  // end of one test
  task tend(input string nm);
    $display("test %0s done", nm);
  endtask
  // counts and verdict
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////
  // main sequence
  initial
  begin
    r = $random(seed);
    repeat (12) @(posedge clk_sys);
    resetn <= 1'h1;
    smpLeft <= {2'h1, r[21:0]};
    smpRight <= {1'h1, r[22:2], 1'h1};
    smpValid <= 1'h1;
    t0 = 0;
    repeat (8)
    begin
      @(negedge clk_sys);
      if (smpReady === 1'h1) t0 = t0 + 1;
    end
    chk(t0, 4);
    bus(1'h0, 7'h31, 8'h0);
    chk(rd, 32'hc0);
    bus(1'h0, 7'h05, 8'h0);
    chk(rd, 32'h0);
    bus(1'h1, 7'h31, 8'hc8); // format set while held in reset wait
    bus(1'h0, 7'h31, 8'h0);
    chk(rd, 32'hc8);
    chk(formatSel, 1'h1);
    tend("defaults");
    waitSt(4'h4, 30000);
    chk(rd[11:10], 2'h3);
    waitF(6);
    chk(leftWord, smpLeft);
    chk(rightWord, smpRight);
    tend("run");
    bus(1'h1, 7'h31, 8'hca); // live toggle on purpose, host advice only
    waitF(2);
    chk(leftWord, neg24(smpLeft));
    chk(rightWord, neg24(smpRight));
    bus(1'h1, 7'h31, 8'hc8);
    tend("polarity");
    slipBits <= 4'h3;
    waitF(1);
    @(posedge clk_sys);
    slipBits <= 4'h0;
    waitF(3);
    bus(1'h0, 7'h32, 8'h0);
    chk(rd[3:0], 4'h4);
    chk(leftWord, smpLeft);
    tend("small drift");
    bus(1'h1, 7'h31, 8'hc9);
    waitSt(4'h5, 20);
    bus(1'h1, 7'h31, 8'hc8);
    waitSt(4'h3, 20);
    tend("mute");
    slipBits <= 4'h6;
    waitF(1);
    @(posedge clk_sys);
    slipBits <= 4'h0;
    waitSt(4'h8, 700);
    waitF(2);
    chk(leftWord, 24'h0);
    waitSt(4'h2, 1000);
    t0 = frameCount;
    waitSt(4'h3, 12000);
    chk(frameCount - t0 > 30 && frameCount - t0 < 34, 1'h1);
    tend("lock");
    bus(1'h1, 7'h31, 8'hcc);
    bus(1'h0, 7'h32, 8'h0);
    chk(rd[3:0] == 4'h5 || rd[3:0] == 4'h7, 1'h1);
    waitSt(4'h7, 20000);
    chk(analogPowerDown_q, 1'h1);
    waitF(2);
    chk(leftWord, 24'h0);
    bus(1'h1, 7'h31, 8'hc8);
    waitSt(4'h0, 5);
    t0 = cyc;
    waitSt(4'h1, 500);
    chk(cyc - t0 > 1010 && cyc - t0 < 1030, 1'h1);
    chk(analogPowerDown_q, 1'h0);
    tend("power");
    bus(1'h1, 7'h31, 8'h88);
    bus(1'h0, 7'h32, 8'h0);
    chk(rd[3:0], 4'h7);
    chk(analogPowerDown_q, 1'h1);
    bus(1'h0, 7'h31, 8'h0);
    chk(rd, 32'h88);
    bus(1'h1, 7'h31, 8'h4d);
    bus(1'h0, 7'h31, 8'h0);
    chk(rd, 32'hc0);
    tend("resets");
    test_done;
  end
  // watchdog, a little past the expected 95000 cycles
  initial
  begin
    repeat (120000) @(posedge clk_sys);
    $display("[FAIL] %0t watchdog", $time);
    bad_count = bad_count + 1;
    test_done;
  end
endmodule
`default_nettype wire
